// *** led_pwm_pkg.sv ***
// Purpose: shared constants for the four-channel led pwm engine
// Assumes: 125 MHz system clock, plain register port with 8-bit data
// Notes:   offsets index one byte each; reserved mode bits read back as written, status bits 7..5 as zero
package led_pwm_pkg;
    // ==========================================================
    // clocking
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned OSC_HZ          = 400_000;            // fine step: 256 x 1.5625 kHz
    localparam int unsigned OSC_DIV         = CLK_HZ / OSC_HZ;    // cycles per fine step
    localparam int unsigned IND_PWM_HZ_X10K = 15_625;             // 1.5625 kHz in units of 0.1 Hz
    localparam int unsigned DIM_HZ          = 190;
    localparam int unsigned DIM_MOD_HZ      = 6_250;
    // fine steps per 190 Hz group period (rounded down)
    localparam int unsigned DIM_STEPS       = OSC_HZ / DIM_HZ;
    // blink: one period = (group_period + 1) x 16384 fine steps (24 Hz .. 1/10.49 Hz)
    localparam int unsigned BLINK_UNIT      = 16_384;
    localparam int unsigned FAST_BLINK_MAX  = 3;                  // group_period 0..3 => 24 Hz..6 Hz

    // ==========================================================
    // register offsets
    localparam logic [3:0] ADDR_MODE_ONE    = 4'h0;
    localparam logic [3:0] ADDR_MODE_TWO    = 4'h1;
    localparam logic [3:0] ADDR_DUTY_BASE   = 4'h2;   // channel duty 0..3 at 2..5
    localparam logic [3:0] ADDR_GROUP_DUTY  = 4'h6;
    localparam logic [3:0] ADDR_GROUP_PER   = 4'h7;
    localparam logic [3:0] ADDR_DRIVE_MODE  = 4'h8;
    localparam logic [3:0] ADDR_STATUS      = 4'h9;

    // field positions
    localparam int unsigned MODE_ONE_SLEEP  = 4;
    localparam int unsigned MODE_TWO_DMBL   = 5;
    localparam int unsigned MODE_TWO_ODRAIN = 2;

    // reset values
    localparam logic [7:0] MODE_ONE_RST     = 8'h00;
    localparam logic [7:0] MODE_TWO_RST     = 8'h00;
    localparam logic [7:0] DUTY_RST         = 8'h00;
    localparam logic [7:0] GROUP_DUTY_RST   = 8'hFF;
    localparam logic [7:0] GROUP_PER_RST    = 8'h00;
    localparam logic [7:0] DRIVE_MODE_RST   = 8'h00;

    // channel drive modes
    typedef enum logic [1:0] {
        DRV_OFF   = 2'b00,
        DRV_ON    = 2'b01,
        DRV_INDIV = 2'b10,
        DRV_GROUP = 2'b11
    } drive_mode_t;
endpackage

// *** led_step_divider.sv ***
// Purpose: one-cycle enable pulse at the fine pwm step rate
// Assumes: single clock, sleep freezes the divider
// Notes:   stands in for the internal oscillator
`timescale 1ns/1ps
module led_step_divider
    import led_pwm_pkg::*;
#(
    parameter int unsigned DIV = OSC_DIV
) (
    input  wire logic i_clk_sys,   // system clock
    input  wire logic i_rst_n,     // async reset, low
    input  wire logic i_run,       // oscillator running
    output logic      o_step       // one-cycle step pulse
);
    initial begin
        if (DIV < 2 || DIV > 65_535) $error("DIV out of range");
    end

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        step_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        step_nxt = 1'b0;
        if (i_run) begin
            if (cnt_r == 16'(DIV - 1)) begin
                cnt_nxt  = 16'h0000;
                step_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r  <= 16'h0000;
            o_step <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            o_step <= step_nxt;
        end
    end
endmodule

// *** led_pwm_dim_blink_engine.sv ***
// Purpose: four-channel led brightness engine with group dim or blink
// Assumes: 125 MHz clock; registers over a plain strobe port, read data one cycle later
// Notes:   output pin model is out, output enable (low = driving); open-drain releases on low
`timescale 1ns/1ps
module led_pwm_dim_blink_engine
    import led_pwm_pkg::*;
#(
    parameter int unsigned CHANNELS = 4,
    parameter int unsigned STEP_DIV = OSC_DIV
) (
    input  wire logic                i_clk_sys,   // system clock
    input  wire logic                i_rst_n,     // async reset, low
    input  wire logic [3:0]          i_addr,      // register address
    input  wire logic [7:0]          i_wdata,     // write data
    input  wire logic                i_wr,        // write strobe
    input  wire logic                i_rd,        // read strobe
    output logic      [7:0]          o_rdata,     // read data, cycle after strobe
    output logic      [CHANNELS-1:0] o_led,       // led output level
    output logic      [CHANNELS-1:0] o_led_oe_n,  // led output enable, low = driving
    output logic                     o_group      // group signal level
);
    initial begin
        if (CHANNELS != 4) $error("CHANNELS must be 4");
    end

    // ==========================================================
    // register file
    logic [7:0] mode_reg_one_r;
    logic [7:0] mode_reg_one_nxt;
    logic [7:0] mode_reg_two_r;
    logic [7:0] mode_reg_two_nxt;
    logic [7:0] channel_duty_r [CHANNELS];
    logic [7:0] channel_duty_nxt [CHANNELS];
    logic [7:0] group_duty_r;
    logic [7:0] group_duty_nxt;
    logic [7:0] group_period_r;
    logic [7:0] group_period_nxt;
    logic [7:0] channel_drive_mode_r;
    logic [7:0] channel_drive_mode_nxt;
    logic [7:0] rdata_nxt;

    logic       sleep;
    logic       dim_or_blink_select;
    logic       open_drain;
    logic       fast_blink;

    always_comb begin
        mode_reg_one_nxt       = mode_reg_one_r;
        mode_reg_two_nxt       = mode_reg_two_r;
        group_duty_nxt         = group_duty_r;
        group_period_nxt       = group_period_r;
        channel_drive_mode_nxt = channel_drive_mode_r;
        for (int i = 0; i < CHANNELS; i++) begin
            channel_duty_nxt[i] = channel_duty_r[i];
        end
        if (i_wr) begin
            unique case (i_addr)
                ADDR_MODE_ONE:   mode_reg_one_nxt       = i_wdata;
                ADDR_MODE_TWO:   mode_reg_two_nxt       = i_wdata;
                ADDR_GROUP_DUTY: group_duty_nxt         = i_wdata;
                ADDR_GROUP_PER:  group_period_nxt       = i_wdata;
                ADDR_DRIVE_MODE: channel_drive_mode_nxt = i_wdata;
                default: begin
                    for (int i = 0; i < CHANNELS; i++) begin
                        if (i_addr == ADDR_DUTY_BASE + 4'(i)) begin
                            channel_duty_nxt[i] = i_wdata;
                        end
                    end
                end
            endcase
        end
    end

    // unmapped addresses read as zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_MODE_ONE:   rdata_nxt = mode_reg_one_r;
                ADDR_MODE_TWO:   rdata_nxt = mode_reg_two_r;
                ADDR_GROUP_DUTY: rdata_nxt = group_duty_r;
                ADDR_GROUP_PER:  rdata_nxt = group_period_r;
                ADDR_DRIVE_MODE: rdata_nxt = channel_drive_mode_r;
                ADDR_STATUS:     rdata_nxt = {3'h0, o_group, o_led};
                default: begin
                    for (int i = 0; i < CHANNELS; i++) begin
                        if (i_addr == ADDR_DUTY_BASE + 4'(i)) begin
                            rdata_nxt = channel_duty_r[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_reg_one_r       <= MODE_ONE_RST;
            mode_reg_two_r       <= MODE_TWO_RST;
            group_duty_r         <= GROUP_DUTY_RST;
            group_period_r       <= GROUP_PER_RST;
            channel_drive_mode_r <= DRIVE_MODE_RST;
            o_rdata              <= 8'h00;
            for (int i = 0; i < CHANNELS; i++) begin
                channel_duty_r[i] <= DUTY_RST;
            end
        end else begin
            mode_reg_one_r       <= mode_reg_one_nxt;
            mode_reg_two_r       <= mode_reg_two_nxt;
            group_duty_r         <= group_duty_nxt;
            group_period_r       <= group_period_nxt;
            channel_drive_mode_r <= channel_drive_mode_nxt;
            o_rdata              <= rdata_nxt;
            for (int i = 0; i < CHANNELS; i++) begin
                channel_duty_r[i] <= channel_duty_nxt[i];
            end
        end
    end

    assign sleep               = mode_reg_one_r[MODE_ONE_SLEEP];
    assign dim_or_blink_select = mode_reg_two_r[MODE_TWO_DMBL];
    assign open_drain          = mode_reg_two_r[MODE_TWO_ODRAIN];
    assign fast_blink          = group_period_r <= 8'(FAST_BLINK_MAX);

    // ==========================================================
    // internal oscillator: fine step enable
    logic step;

    led_step_divider #(
        .DIV (STEP_DIV)
    ) u_osc (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_run     (!sleep),
        .o_step    (step)
    );

    // ==========================================================
    // timebases; all counters advance only on step, so sleep freezes them
    logic [7:0]  fine_r;
    logic [7:0]  fine_nxt;
    logic [11:0] dim_r;
    logic [11:0] dim_nxt;
    logic [21:0] blink_r;
    logic [21:0] blink_nxt;
    logic [21:0] blink_last;
    logic [7:0]  blink_phase;
    logic        group_nxt;

    // blink length: (period + 1) x unit fine steps
    assign blink_last  = 22'({6'h00, group_period_r} + 22'h1) * 22'(BLINK_UNIT) - 22'h1;
    assign blink_phase = 8'(blink_r / (22'({6'h00, group_period_r} + 22'h1) * 22'(BLINK_UNIT / 256)));

    always_comb begin
        fine_nxt  = fine_r;
        dim_nxt   = dim_r;
        blink_nxt = blink_r;
        if (step) begin
            fine_nxt  = fine_r + 8'h01;
            dim_nxt   = (dim_r == 12'(DIM_STEPS - 1)) ? 12'h000 : dim_r + 12'h001;
            blink_nxt = (blink_r >= blink_last) ? 22'h000000 : blink_r + 22'h000001;
        end
    end

    // group signal: dim uses 16 steps, blink 64 (fast) or 256 (slow)
    always_comb begin
        if (!dim_or_blink_select) begin
            group_nxt = 8'(dim_r / 12'(DIM_STEPS / 16)) < {4'h0, group_duty_r[7:4]};
        end else if (fast_blink) begin
            group_nxt = blink_phase[7:2] < group_duty_r[7:2];
        end else begin
            group_nxt = blink_phase < group_duty_r;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fine_r  <= 8'h00;
            dim_r   <= 12'h000;
            blink_r <= 22'h000000;
            o_group <= 1'b0;
        end else begin
            fine_r  <= fine_nxt;
            dim_r   <= dim_nxt;
            blink_r <= blink_nxt;
            if (step) begin
                o_group <= group_nxt;
            end
        end
    end

    // ==========================================================
    // per-channel output combine
    wire logic [CHANNELS-1:0] led_nxt;
    wire logic [CHANNELS-1:0] oe_n_nxt;

    generate
        for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
            drive_mode_t mode;
            logic        ind_pwm;
            logic        fine_pwm;
            logic        mod_pwm;
            logic        led_c;
            assign mode     = drive_mode_t'(channel_drive_mode_r[2*c +: 2]);
            assign fine_pwm = fine_r < channel_duty_r[c];
            // 6.25 kHz: 64 steps, four periods per 1.5625 kHz frame
            assign mod_pwm  = fine_r[5:0] < channel_duty_r[c][7:2];
            assign ind_pwm  = dim_or_blink_select ? fine_pwm : mod_pwm;

            // group_nxt, not o_group: led and group register on the same step, no lag
            always_comb begin
                unique case (mode)
                    DRV_OFF:   led_c = 1'b0;
                    DRV_ON:    led_c = 1'b1;
                    DRV_INDIV: led_c = fine_pwm;
                    DRV_GROUP: led_c = ind_pwm && group_nxt;
                endcase
            end
            assign led_nxt[c]  = led_c;
            // open drain releases the pin while the led is off
            assign oe_n_nxt[c] = open_drain && !led_c;
        end
    endgenerate

    // outputs hold while asleep because step never fires
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_led      <= {CHANNELS{1'b1}};
            o_led_oe_n <= {CHANNELS{1'b0}};
        end else if (step) begin
            o_led      <= led_nxt;
            o_led_oe_n <= oe_n_nxt;
        end
    end
endmodule

// *** led_pwm_chk.sv ***
// Purpose: port-level checks for the led pwm engine
// Assumes: register writes shadowed from the strobe port
// Notes:   settled means no write and no sleep for two steps
`timescale 1ns/1ps
module led_pwm_chk
    import led_pwm_pkg::*;
#(
    parameter int unsigned CHANNELS = 4,
    parameter int unsigned STEP_DIV = OSC_DIV
) (
    input wire logic                i_clk_sys,   // system clock
    input wire logic                i_rst_n,     // async reset, low
    input wire logic [3:0]          i_addr,      // address
    input wire logic [7:0]          i_wdata,     // write data
    input wire logic                i_wr,        // write strobe
    input wire logic                i_rd,        // read strobe
    input wire logic [7:0]          o_rdata,     // read data
    input wire logic [CHANNELS-1:0] o_led,       // led level
    input wire logic [CHANNELS-1:0] o_led_oe_n,  // enable, low drives
    input wire logic                o_group      // group level
);
    // =====
    // shadow registers
    logic [7:0]          drive_r;
    logic                sleep_r, od_r, settled;
    logic [15:0]         quiet_r;
    logic [CHANNELS-1:0] on_m, off_m, grp_m;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drive_r <= DRIVE_MODE_RST;
            sleep_r <= MODE_ONE_RST[MODE_ONE_SLEEP];
            od_r    <= MODE_TWO_RST[MODE_TWO_ODRAIN];
            quiet_r <= 16'h0000;
        end else begin
            // any write may move the outputs, so the wait restarts
            quiet_r <= (i_wr || sleep_r) ? 16'h0000 : quiet_r + 16'(quiet_r != 16'hFFFF);
            if (i_wr && i_addr == ADDR_DRIVE_MODE) drive_r <= i_wdata;
            if (i_wr && i_addr == ADDR_MODE_ONE) sleep_r <= i_wdata[MODE_ONE_SLEEP];
            if (i_wr && i_addr == ADDR_MODE_TWO) od_r <= i_wdata[MODE_TWO_ODRAIN];
        end
    end
    assign settled = 32'(quiet_r) > 2 * STEP_DIV + 2;
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            on_m[c]  = drive_r[2*c +: 2] == DRV_ON;
            off_m[c] = drive_r[2*c +: 2] == DRV_OFF;
            grp_m[c] = drive_r[2*c +: 2] == DRV_GROUP;
        end
    end
    // =====
    // properties
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    property p_reset_vals; $rose(i_rst_n) |-> o_led == '1 && o_led_oe_n == '0 && !o_group; endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("outputs not high after reset");
    property p_fixed_mode; settled |-> (o_led & on_m) == on_m && (o_led & off_m) == '0; endproperty
    a_fixed_mode: assert property (p_fixed_mode) else $error("fixed on or off channel moved");
    property p_group_gate; settled && !o_group |-> (o_led & grp_m) == '0; endproperty
    a_group_gate: assert property (p_group_gate) else $error("led active without group");
    property p_drive_kind; settled |-> o_led_oe_n == (od_r ? ~o_led : '0); endproperty
    a_drive_kind: assert property (p_drive_kind) else $error("output enable wrong for drive kind");
    property p_sleep_freeze; sleep_r && $past(sleep_r) |=> $stable(o_led) && $stable(o_group); endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("outputs moved while asleep");
    property p_step_gap; $changed(o_led) |=> $stable(o_led) [*3]; endproperty
    a_step_gap: assert property (p_step_gap) else $error("led changed between steps");
    property p_status; i_rd && i_addr == ADDR_STATUS |=> o_rdata == {3'b000, $past(o_group), $past(o_led)}; endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    property p_unmapped; i_rd && i_addr > ADDR_STATUS |=> o_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rd_idle; !i_rd |=> o_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    c_sleep: cover property (sleep_r && $past(sleep_r));
    c_odrain: cover property (settled && od_r && o_led != '0);
    c_group: cover property (settled && o_group);
    c_gated: cover property (settled && o_group && (o_led & grp_m) != '0);
endmodule

// *** led_load_model.sv ***
// Purpose: leds on the four outputs, counting lit clocks
// Assumes: a led is lit only while its pin is driven active
// Notes:   released pin is pulled up, so it never lights
`timescale 1ns/1ps
module led_load_model (
    input  wire logic        i_clk_sys,   // system clock
    input  wire logic        i_rst_n,     // async reset, low
    input  wire logic [3:0]  i_led,       // led levels
    input  wire logic [3:0]  i_led_oe_n,  // enables, low drives
    input  wire logic        i_group,     // group level
    input  wire logic        i_start,     // start a window
    input  wire logic [16:0] i_len,       // window in clocks
    output logic      [84:0] o_cnt,       // {group, ch3..ch0}
    output logic             o_done       // level, window over
);
    logic [16:0] left_r;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            left_r <= '0;
            o_cnt  <= '0;
            o_done <= 1'b0;
        end else if (i_start) begin
            left_r <= i_len;
            o_cnt  <= '0;
            o_done <= 1'b0;
        end else if (left_r != 17'd0) begin
            left_r <= left_r - 17'd1;
            o_done <= left_r == 17'd1;
            for (int c = 0; c < 4; c++)
                o_cnt[17*c +: 17] <= o_cnt[17*c +: 17] + 17'(i_led[c] & ~i_led_oe_n[c]);
            o_cnt[84:68] <= o_cnt[84:68] + 17'(i_group);
        end
    end
endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the led pwm engine
// Assumes: STEP_DIV of 4, one pwm frame is 1024 clocks
// Notes:   driver queues expectations, monitor compares
`timescale 1ns/1ps
module tb_top;
    import led_pwm_pkg::*;
    localparam int unsigned STEP_DIV = 4;
    localparam int unsigned CHANNELS = 4;
    localparam logic [16:0] FRAME    = 17'(256 * STEP_DIV);
    logic        i_clk_sys, i_rst_n, i_wr, i_rd, o_group, m_start, m_done, rd_q, done_q;
    logic [3:0]  i_addr, o_led, o_led_oe_n;
    logic [7:0]  i_wdata, o_rdata;
    logic [16:0] m_len;
    logic [84:0] m_cnt;
    logic [7:0]  q_rd[$];
    logic [84:0] q_cnt[$];
    logic [7:0]  duty[4];
    int          fails, compares;
    led_pwm_dim_blink_engine #(.STEP_DIV(STEP_DIV)) i_led_pwm_dim_blink_engine (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_led(o_led), .o_led_oe_n(o_led_oe_n), .o_group(o_group));
    led_load_model i_led_load_model (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_led(o_led), .i_led_oe_n(o_led_oe_n),
        .i_group(o_group), .i_start(m_start), .i_len(m_len), .o_cnt(m_cnt), .o_done(m_done));
    // =====
    // tasks
    function automatic logic [84:0] pk(input logic [16:0] c0, c1, c2, c3, g);
        return {g, c3, c2, c1, c0};
    endfunction
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmpc(input logic [84:0] got, input logic [84:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // strobes drop one edge later, so back-to-back calls never collide
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        q_rd.push_back(e);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic measure(input logic [16:0] len, input logic [84:0] e);
        repeat (3 * STEP_DIV) @(posedge i_clk_sys);
        q_cnt.push_back(e);
        m_len   <= len;
        m_start <= 1'b1;
        @(posedge i_clk_sys);
        m_start <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        for (int n = 0; n < 70000 && m_done !== 1'b1; n++) @(posedge i_clk_sys);
    endtask
    // =====
    // clock, monitor, watchdog
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        rd_q   <= i_rd;
        done_q <= m_done;
        if (rd_q) cmp8(o_rdata, q_rd.pop_front());
        if (m_done && !done_q) cmpc(m_cnt, q_cnt.pop_front());
    end
    initial begin
        repeat (100000) @(posedge i_clk_sys);
        fails++;
        report_and_stop();
    end
    // =====
    // main sequence
    initial begin
        {fails, compares} = '0;
        {i_rst_n, i_wr, i_rd, m_start} = '0;
        {i_addr, i_wdata, m_len} = '0;
        void'($urandom(32'h221bf962));
        repeat (3) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        cmp8({3'b000, o_group, o_led}, 8'h0F);
        cmp8({4'h0, o_led_oe_n}, 8'h00);
        for (int c = 0; c < 4; c++) begin
            duty[c] = 8'($urandom);
            wr(ADDR_DUTY_BASE + 4'(c), duty[c]);
        end
        wr(ADDR_GROUP_DUTY, 8'h00);
        for (int c = 0; c < 4; c++) rd(ADDR_DUTY_BASE + 4'(c), duty[c]);
        for (int a = 10; a < 16; a++) rd(4'(a), 8'h00);
        wr(ADDR_DRIVE_MODE, 8'h11);
        measure(FRAME, pk(FRAME, 0, FRAME, 0, 0));
        rd(ADDR_STATUS, 8'h05);
        wr(ADDR_MODE_TWO, 8'h04);
        measure(FRAME, pk(FRAME, 0, FRAME, 0, 0));
        wr(ADDR_MODE_TWO, 8'h20);
        wr(ADDR_GROUP_PER, 8'($urandom));
        wr(ADDR_DRIVE_MODE, 8'hAA);
        measure(FRAME, pk(17'(duty[0] * STEP_DIV), 17'(duty[1] * STEP_DIV), 17'(duty[2] * STEP_DIV),
                17'(duty[3] * STEP_DIV), 0));
        wr(ADDR_MODE_TWO, 8'h00);
        wr(ADDR_DRIVE_MODE, 8'hFF);
        measure(FRAME, pk(0, 0, 0, 0, 0));
        wr(ADDR_MODE_TWO, 8'h20);
        wr(ADDR_GROUP_PER, 8'h00);
        wr(ADDR_GROUP_DUTY, 8'h80);
        wr(ADDR_DRIVE_MODE, 8'h57);
        measure(17'h10000, pk(17'(duty[0] * 32 * STEP_DIV), 17'h10000, 17'h10000, 17'h10000,
                17'((8'h80 >> 2) * (BLINK_UNIT / 64) * STEP_DIV)));
        wr(ADDR_MODE_TWO, 8'h00);
        wr(ADDR_GROUP_DUTY, 8'h80);
        wr(ADDR_DRIVE_MODE, 8'h54);
        measure(17'(DIM_STEPS * STEP_DIV), pk(0, 17'(DIM_STEPS * STEP_DIV), 17'(DIM_STEPS * STEP_DIV),
                17'(DIM_STEPS * STEP_DIV), 17'((8'h80 >> 4) * (DIM_STEPS / 16) * STEP_DIV)));
        // channel 0 in group mode; window sits inside one group-high stretch
        wr(ADDR_DRIVE_MODE, 8'h57);
        wr(ADDR_DUTY_BASE, 8'h47);
        for (int n = 0; n < 9000 && o_group !== 1'b0; n++) @(posedge i_clk_sys);
        for (int n = 0; n < 9000 && o_group !== 1'b1; n++) @(posedge i_clk_sys);
        measure(17'(4 * FRAME), pk(17'((8'h47 >> 2) * 16 * STEP_DIV), 17'(4 * FRAME), 17'(4 * FRAME),
                17'(4 * FRAME), 17'(4 * FRAME)));
        wr(ADDR_DRIVE_MODE, 8'h55);
        wr(ADDR_GROUP_DUTY, 8'h00);
        repeat (3 * STEP_DIV) @(posedge i_clk_sys);
        wr(ADDR_MODE_ONE, 8'h10);
        wr(ADDR_DRIVE_MODE, 8'h00);
        measure(FRAME, pk(FRAME, FRAME, FRAME, FRAME, 0));
        wr(ADDR_MODE_ONE, 8'h00);
        measure(FRAME, pk(0, 0, 0, 0, 0));
        // mid-run reset zeroes the timebases, so the slow blink phase is known
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        wr(ADDR_GROUP_PER, 8'h04);
        wr(ADDR_GROUP_DUTY, 8'h02);
        wr(ADDR_MODE_TWO, 8'h20);
        measure(FRAME, pk(0, 0, 0, 0, FRAME));
        report_and_stop();
    end
endmodule
bind led_pwm_dim_blink_engine led_pwm_chk #(.CHANNELS(CHANNELS), .STEP_DIV(STEP_DIV)) i_led_pwm_chk (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_led(o_led), .o_led_oe_n(o_led_oe_n), .o_group(o_group));
